// ==== hdl/flash_host.sv ====
// host sequencer for a 128K x 8 parallel flash: read, signature, program, chip erase, abort
// assumes one flash on the pins and an external switch that turns vpp_en into the program supply
//
// Summary of operation
// RQ1 - read drives chip select, output enable low
// RQ2 - supply high: set-read before array reads
// RQ3 - signature read: high voltage, others low
// RQ4 - signature bytes at addresses zero and one
// RQ5 - chip select high means standby, high impedance
// RQ6 - writing 00H returns device to read
// RQ7 - 90H with supply high selects signature
// RQ8 - erase needs two consecutive 20H writes
// RQ9 - A0H write ends the erase pulse
// RQ10 - verify address latched on falling strobe
// RQ11 - device times pulses with stop timer
// RQ12 - verify every byte after each erase; code resumes verify at the failing byte after a re-erase
// RQ13 - 40H, then address and data write
// RQ14 - next rising strobe ends program pulse
// RQ15 - C0H then read verifies programmed byte
// RQ16 - program address kept through verify
// RQ17 - two FFH writes abort to read
// RQ18 - abort accepted anywhere in a sequence
// RQ19 - power-up leaves command register in read
// RQ20 - commands taken only with supply high
// RQ21 - at most 25 program loops per byte
// RQ22 - verify passes on data or all ones
`timescale 1ns/100ps
`include "flash_host_regs.svh"

module flash_host #(
    parameter int ERASE_CYC = `ERASE_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire flash_host_pkg::op_e cmd_op,
    input wire logic [`ADDR_W-1:0] cmd_addr,
    input wire logic [`DATA_W-1:0] cmd_data,
    input wire logic abort_req,
    output logic resp_valid,
    output logic [`DATA_W-1:0] resp_data,
    output logic resp_ok,
    output logic vpp_en,
    output logic sig_hv_en,
    output logic ce_n,
    output logic oe_n,
    output logic we_n,
    output logic [`ADDR_W-1:0] addr_lines,
    output logic [`DATA_W-1:0] data_lines_out,
    output logic data_lines_oe_n,
    input wire logic [`DATA_W-1:0] data_lines_in
);
    import flash_host_pkg::*;

    state_e state_reg, state_next;
    op_e op_reg;
    logic [`ADDR_W-1:0] addr_reg;
    logic [`DATA_W-1:0] data_reg;
    logic [20:0] tmr_reg;
    logic [9:0] tries_reg;
    logic ok_reg, sent_reg, abort_pend_reg;
    logic [`DATA_W-1:0] last_wr_reg, prev_wr_reg;
    logic bus_req, bus_wr, bus_hv, bus_done, abort_take, pass, read_mode;
    logic [`ADDR_W-1:0] bus_addr;
    logic [`DATA_W-1:0] bus_wdata, bus_rdata;

    function automatic logic is_bus_state(input state_e s);
        return s inside {ST_CMD1, ST_CMD2, ST_VCMD, ST_VREAD, ST_READ, ST_EXIT};
    endfunction

    function automatic logic [`DATA_W-1:0] first_code(input op_e op);
        unique case (op)
            OP_SIG_CMD: return `CMD_SIGNATURE; // RQ7
            OP_PROGRAM: return `CMD_PROGRAM; // RQ13
            OP_ERASE: return `CMD_ERASE; // RQ8
            default: return `CMD_RESET; // RQ17
        endcase
    endfunction

    // abort waits for the bus cycle in flight so the pins never see a torn cycle
    assign abort_take = abort_pend_reg && !sent_reg && op_reg != OP_ABORT && // RQ18
        state_reg inside {ST_CMD1, ST_CMD2, ST_PULSE, ST_VCMD, ST_RECOV, ST_VREAD, ST_EXIT};
    assign bus_req = is_bus_state(state_reg) && !sent_reg && !abort_take;
    assign pass = (op_reg == OP_ERASE) ? (bus_rdata == `ERASED_BYTE) : (bus_rdata == data_reg); // RQ22
    assign read_mode = last_wr_reg == `CMD_SET_READ || (last_wr_reg == `CMD_RESET && prev_wr_reg == `CMD_RESET);
    assign cmd_ready = state_reg == ST_IDLE;
    assign resp_valid = state_reg == ST_DONE;
    assign resp_ok = ok_reg;
    logic vpp_hold;

    // held through a command-mode signature read too, so the closing 00H write still has the supply
    assign vpp_en = vpp_hold;

    always_comb begin
        bus_wr = 1'b1;
        bus_hv = 1'b0;
        bus_addr = addr_reg;
        bus_wdata = `CMD_SET_READ;
        unique case (state_reg)
            ST_CMD1: bus_wdata = first_code(op_reg);
            ST_CMD2: bus_wdata = (op_reg == OP_PROGRAM) ? data_reg : first_code(op_reg); // RQ8 RQ13 RQ17
            ST_VCMD: bus_wdata = (op_reg == OP_ERASE) ? `CMD_ERASE_VERIFY : `CMD_PROG_VERIFY; // RQ9 RQ10 RQ15
            ST_VREAD: bus_wr = 1'b0;
            ST_READ: begin
                bus_wr = 1'b0; // RQ1
                bus_hv = op_reg == OP_SIG_HV; // RQ3
                if (op_reg != OP_READ) begin
                    bus_addr = `ADDR_FIRST;
                    bus_addr[`SIG_ADDR_BIT] = addr_reg[`SIG_ADDR_BIT];
                end
            end
            default: bus_wdata = `CMD_SET_READ; // RQ6
        endcase
    end

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (cmd_valid) begin
                    state_next = (cmd_op == OP_READ || cmd_op == OP_SIG_HV) ? ST_READ : ST_VPP;
                end
            end
            ST_VPP: if (tmr_reg == 21'h000000) state_next = ST_CMD1;
            ST_CMD1: if (bus_done) state_next = (op_reg == OP_SIG_CMD) ? ST_READ : ST_CMD2;
            ST_CMD2: if (bus_done) state_next = (op_reg == OP_ABORT) ? ST_DONE : ST_PULSE;
            ST_PULSE: if (tmr_reg == 21'h000000) state_next = ST_VCMD; // RQ9
            ST_VCMD: if (bus_done) state_next = ST_RECOV;
            ST_RECOV: if (tmr_reg == 21'h000000) state_next = ST_VREAD;
            ST_VREAD: if (bus_done) state_next = ST_CHECK;
            ST_CHECK: begin
                if (pass) begin
                    state_next = (op_reg == OP_ERASE && addr_reg != `ADDR_LAST) ? ST_VCMD : ST_EXIT; // RQ12
                end else begin
                    state_next = (tries_reg < ((op_reg == OP_ERASE) ? `ERASE_MAX_LOOPS : `PROG_MAX_LOOPS)) ?
                        ST_CMD1 : ST_EXIT; // RQ21
                end
            end
            ST_READ: if (bus_done) state_next = (op_reg == OP_SIG_CMD) ? ST_EXIT : ST_DONE;
            ST_EXIT: if (bus_done) state_next = ST_DONE;
            ST_DONE: state_next = ST_IDLE;
        endcase
        if (abort_take) begin
            state_next = ST_CMD1; // RQ17
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // the erase pulse is ended by our A0H write; the timer only sets its least length
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tmr_reg <= 21'h000000;
        end else if (state_next != state_reg && state_next == ST_VPP) begin
            tmr_reg <= 21'(`VPP_CYC - 1);
        end else if (state_next != state_reg && state_next == ST_PULSE) begin
            tmr_reg <= (op_reg == OP_ERASE) ? 21'(ERASE_CYC - 1) : 21'(`PROG_CYC - 1);
        end else if (state_next != state_reg && state_next == ST_RECOV) begin
            tmr_reg <= 21'(`RECOV_CYC - 1);
        end else if (tmr_reg != 21'h000000) begin
            tmr_reg <= tmr_reg - 21'h000001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            op_reg <= OP_READ;
            addr_reg <= `ADDR_FIRST;
            data_reg <= `CMD_SET_READ;
            tries_reg <= 10'h000;
            ok_reg <= 1'b0;
        end else if (state_reg == ST_IDLE && cmd_valid) begin
            op_reg <= cmd_op;
            addr_reg <= (cmd_op == OP_ERASE) ? `ADDR_FIRST : cmd_addr;
            data_reg <= cmd_data;
            tries_reg <= 10'h000;
            ok_reg <= cmd_op inside {OP_READ, OP_SIG_HV, OP_SIG_CMD, OP_ABORT};
        end else if (abort_take) begin
            op_reg <= OP_ABORT;
            ok_reg <= 1'b0;
        end else begin
            if (state_next == ST_PULSE && state_reg != ST_PULSE) begin
                tries_reg <= tries_reg + 10'h001;
            end
            if (state_reg == ST_CHECK && pass) begin
                if (op_reg == OP_ERASE && addr_reg != `ADDR_LAST) begin
                    addr_reg <= addr_reg + `ADDR_W'(1); // RQ12
                end else begin
                    ok_reg <= 1'b1;
                end
            end
        end
    end

    // supply stays up until the device is back in read mode
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            vpp_hold <= 1'b0;
        end else if (state_next == ST_VPP) begin
            vpp_hold <= 1'b1;
        end else if (state_reg == ST_DONE) begin
            vpp_hold <= 1'b0; // RQ2
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            abort_pend_reg <= 1'b0;
        end else if (state_reg == ST_DONE) begin
            abort_pend_reg <= 1'b0;
        end else begin
            abort_pend_reg <= (abort_pend_reg && !abort_take) ||
                (abort_req && state_reg != ST_IDLE && op_reg != OP_ABORT);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sent_reg <= 1'b0;
        end else if (bus_done) begin
            sent_reg <= 1'b0;
        end else if (bus_req) begin
            sent_reg <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            resp_data <= `CMD_SET_READ;
        end else if (bus_done && (state_reg == ST_READ || state_reg == ST_VREAD)) begin
            resp_data <= bus_rdata;
        end
    end

    // power-up leaves the device in read mode, so the record starts there
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            last_wr_reg <= `CMD_SET_READ;
            prev_wr_reg <= `CMD_SET_READ;
        end else if (bus_done && is_bus_state(state_reg) && state_reg != ST_READ && state_reg != ST_VREAD) begin
            last_wr_reg <= bus_wdata;
            prev_wr_reg <= last_wr_reg;
        end
    end

    flash_bus_cycle u_cycle (
        .ref_clk(ref_clk),
        .rst(rst),
        .start(bus_req),
        .wr(bus_wr),
        .hv(bus_hv),
        .addr(bus_addr),
        .wdata(bus_wdata),
        .done(bus_done),
        .rdata(bus_rdata),
        .ce_n(ce_n),
        .oe_n(oe_n),
        .we_n(we_n),
        .sig_hv_en(sig_hv_en),
        .addr_lines(addr_lines),
        .data_lines_out(data_lines_out),
        .data_lines_oe_n(data_lines_oe_n),
        .data_lines_in(data_lines_in)
    );

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    AST_VPP_DROP_IN_READ: assert property ($fell(vpp_en) |-> $past(read_mode)) // RQ2
        else $error("supply dropped before device returned to read mode");
    AST_ERASE_DOUBLE: assert property ($rose(state_reg == ST_PULSE) && op_reg == OP_ERASE |->
        last_wr_reg == `CMD_ERASE && prev_wr_reg == `CMD_ERASE) // RQ8
        else $error("erase pulse without two erase writes");
    AST_ERASE_STOP: assert property (state_reg == ST_PULSE && tmr_reg == 21'h000000 && !abort_take |=>
        state_reg == ST_VCMD ##[1:40] bus_done) // RQ9
        else $error("pulse not ended by verify command write");
    AST_EV_ADDR: assert property (bus_req && state_reg == ST_VCMD && op_reg == OP_ERASE |->
        bus_addr == addr_reg && bus_wdata == `CMD_ERASE_VERIFY) // RQ10
        else $error("erase verify write carries wrong address or code");
    AST_ALL_BYTES: assert property (state_reg == ST_CHECK && op_reg == OP_ERASE && pass && state_next == ST_EXIT
        |-> addr_reg == `ADDR_LAST) // RQ12
        else $error("erase finished before every byte verified");
    AST_PROG_WRITE: assert property (bus_req && state_reg == ST_CMD2 && op_reg == OP_PROGRAM |->
        bus_wdata == data_reg && bus_addr == addr_reg && last_wr_reg == `CMD_PROGRAM) // RQ13
        else $error("program data write malformed");
    AST_PV_ORDER: assert property ($rose(state_reg == ST_VREAD) && op_reg == OP_PROGRAM |->
        $past(state_reg) == ST_RECOV && last_wr_reg == `CMD_PROG_VERIFY) // RQ15
        else $error("program verify read not preceded by verify command and recovery");
    AST_LOOP_LIMIT: assert property (state_reg == ST_CHECK && op_reg == OP_PROGRAM && !pass &&
        tries_reg == `PROG_MAX_LOOPS |=> state_reg == ST_EXIT ##1 !ok_reg) // RQ21
        else $error("program retried beyond loop limit");
    AST_PASS_EXIT: assert property (state_reg == ST_CHECK && op_reg == OP_PROGRAM && pass |=>
        state_reg == ST_EXIT && ok_reg) // RQ22
        else $error("passing program verify did not finish");

    COV_ERASE_OK: cover property (state_reg == ST_DONE && op_reg == OP_ERASE && ok_reg);
    COV_PROG_RETRY: cover property (state_reg == ST_CHECK && op_reg == OP_PROGRAM && !pass);
    COV_ABORT: cover property (abort_take);
    COV_SIG_CMD: cover property (state_reg == ST_READ && bus_done && op_reg == OP_SIG_CMD);
endmodule

// ==== hdl/flash_host_regs.svh ====
// bus pin timing, command codes and algorithm limits for the flash host controller
// assumes a 125 MHz ref_clk; cycle counts derive from the printed times
`ifndef FLASH_HOST_REGS_SVH
`define FLASH_HOST_REGS_SVH

`define ADDR_W 17
`define DATA_W 8
`define ADDR_FIRST 17'h00000
`define ADDR_LAST 17'h1ffff
`define SIG_ADDR_BIT 0

`define CLK_MHZ 125
`define T_WP_NS 40
`define T_WC_NS 120
`define T_ACC_NS 120
`define T_VPP_NS 100
`define T_PROG_US 10
`define T_RECOV_US 6
`define T_ERASE_US 9500

// least times, rounded up to whole cycles
`define WP_CYC ((`T_WP_NS * `CLK_MHZ + 999) / 1000)
`define WC_CYC ((`T_WC_NS * `CLK_MHZ + 999) / 1000)
`define ACC_CYC ((`T_ACC_NS * `CLK_MHZ + 999) / 1000)
`define VPP_CYC ((`T_VPP_NS * `CLK_MHZ + 999) / 1000)
`define PROG_CYC (`T_PROG_US * `CLK_MHZ)
`define RECOV_CYC (`T_RECOV_US * `CLK_MHZ)
`define ERASE_CYC (`T_ERASE_US * `CLK_MHZ)
`define WHOLD_CYC (`WC_CYC - `WP_CYC - 1)

`define CMD_SET_READ 8'h00
`define CMD_SIGNATURE 8'h90
`define CMD_ERASE 8'h20
`define CMD_ERASE_VERIFY 8'ha0
`define CMD_PROGRAM 8'h40
`define CMD_PROG_VERIFY 8'hc0
`define CMD_RESET 8'hff
`define ERASED_BYTE 8'hff

`define PROG_MAX_LOOPS 10'd25
`define ERASE_MAX_LOOPS 10'd1000

`endif

// ==== hdl/flash_host_pkg.sv ====
// types shared by the flash host controller and its bus cycle engine
// assumes flash_host_regs.svh supplies all numeric constants
package flash_host_pkg;

    typedef enum logic [2:0] {
        OP_READ = 3'b000,
        OP_SIG_HV = 3'b001,
        OP_SIG_CMD = 3'b010,
        OP_PROGRAM = 3'b011,
        OP_ERASE = 3'b100,
        OP_ABORT = 3'b101
    } op_e;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_VPP = 4'b0001,
        ST_CMD1 = 4'b0010,
        ST_CMD2 = 4'b0011,
        ST_PULSE = 4'b0100,
        ST_VCMD = 4'b0101,
        ST_RECOV = 4'b0110,
        ST_VREAD = 4'b0111,
        ST_CHECK = 4'b1000,
        ST_READ = 4'b1001,
        ST_EXIT = 4'b1010,
        ST_DONE = 4'b1011
    } state_e;

    typedef enum logic [1:0] {
        B_IDLE = 2'b00,
        B_SETUP = 2'b01,
        B_STROBE = 2'b10,
        B_HOLD = 2'b11
    } bus_state_e;

endpackage

// ==== hdl/flash_bus_cycle.sv ====
// one asynchronous read or write cycle on the flash pins, timed in ref_clk cycles
// assumes start only while idle; inputs are synchronous to ref_clk
`timescale 1ns/100ps
`include "flash_host_regs.svh"

module flash_bus_cycle (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic start,
    input wire logic wr,
    input wire logic hv,
    input wire logic [`ADDR_W-1:0] addr,
    input wire logic [`DATA_W-1:0] wdata,
    output logic done,
    output logic [`DATA_W-1:0] rdata,
    output logic ce_n,
    output logic oe_n,
    output logic we_n,
    output logic sig_hv_en,
    output logic [`ADDR_W-1:0] addr_lines,
    output logic [`DATA_W-1:0] data_lines_out,
    output logic data_lines_oe_n,
    input wire logic [`DATA_W-1:0] data_lines_in
);
    import flash_host_pkg::*;

    bus_state_e state_reg;
    logic [4:0] cnt_reg;
    logic wr_reg;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_reg <= B_IDLE;
            cnt_reg <= 5'h00;
        end else begin
            unique case (state_reg)
                B_IDLE: begin
                    if (start) begin
                        state_reg <= B_SETUP;
                    end
                end
                B_SETUP: begin
                    state_reg <= B_STROBE;
                    cnt_reg <= wr_reg ? 5'(`WP_CYC - 1) : 5'(`ACC_CYC - 1);
                end
                B_STROBE: begin
                    if (cnt_reg == 5'h00) begin
                        state_reg <= B_HOLD;
                        cnt_reg <= wr_reg ? 5'(`WHOLD_CYC - 1) : 5'h00;
                    end else begin
                        cnt_reg <= cnt_reg - 5'h01;
                    end
                end
                B_HOLD: begin
                    if (cnt_reg == 5'h00) begin
                        state_reg <= B_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg - 5'h01;
                    end
                end
            endcase
        end
    end

    // address and data stay put for the whole cycle, so the falling and rising strobe edges both see them
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ce_n <= 1'b1;
            oe_n <= 1'b1;
            we_n <= 1'b1;
            sig_hv_en <= 1'b0;
            addr_lines <= `ADDR_FIRST;
            data_lines_out <= `CMD_SET_READ;
            data_lines_oe_n <= 1'b1;
            wr_reg <= 1'b0;
            rdata <= `CMD_SET_READ;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (state_reg == B_IDLE && start) begin
                addr_lines <= addr;
                ce_n <= 1'b0;
                wr_reg <= wr;
                sig_hv_en <= hv;
                data_lines_out <= wdata;
                data_lines_oe_n <= !wr;
            end else if (state_reg == B_SETUP) begin
                we_n <= !wr_reg;
                oe_n <= wr_reg;
            end else if (state_reg == B_STROBE && cnt_reg == 5'h00) begin
                we_n <= 1'b1;
                oe_n <= 1'b1;
                if (!wr_reg) begin
                    rdata <= data_lines_in;
                end
            end else if (state_reg == B_HOLD && cnt_reg == 5'h00) begin
                ce_n <= 1'b1;
                data_lines_oe_n <= 1'b1;
                sig_hv_en <= 1'b0;
                done <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    AST_READ_PINS: assert property (!oe_n |-> !ce_n && we_n && data_lines_oe_n) // RQ1
        else $error("output enable low outside a clean read");
    AST_HV_OTHERS_LOW: assert property (sig_hv_en |-> (addr_lines >> 1) == '0) // RQ3
        else $error("address lines not low while signature voltage applied");
    AST_WE_ADDR_STABLE: assert property ($fell(we_n) |-> (!we_n && $stable(addr_lines))[*5] ##1 we_n) // RQ10
        else $error("write strobe width or address stability wrong");
    AST_WE_DATA_DRIVEN: assert property (!we_n |-> !data_lines_oe_n && !ce_n && oe_n && $stable(data_lines_out)) // RQ13
        else $error("data not driven steadily during write strobe");
endmodule

// ==== tb/flash_device_model.sv ====
// behavioural 128K x 8 flash device seen through its pins
// assumes vpp switches at once; pulse and recovery times are checked in ns
`timescale 1ns/100ps

module flash_device_model #(
    parameter logic [7:0] MFG_CODE = 8'h5c, // arbitrary value
    parameter logic [7:0] DEV_CODE = 8'h3a, // arbitrary value
    parameter real ERASE_NS = 9500000.0
) (
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic vpp,
    input wire logic sig_hv,
    input wire logic [16:0] addr,
    input wire logic [7:0] bus,
    input wire integer skip_until,
    output logic [7:0] dev_q
);
    typedef enum logic [2:0] {M_READ, M_SIG, M_ERASE1, M_ERASING, M_EVER, M_PROG1, M_PROGGING, M_PVER} mode_e;
    logic [7:0] mem [0:131071];
    mode_e mode;
    logic [16:0] wa, va, pa;
    logic [7:0] pd, prev, q;
    real t_pulse, t_wrise;
    int pulses, erases, viol;

    initial begin
        for (int a = 0; a < 131072; a++) mem[a] = {1'b0, a[6:0] ^ a[13:7]};
        mode = M_READ;
        prev = 8'h00;
        pulses = 0;
        erases = 0;
        viol = 0;
        t_pulse = 0.0;
        t_wrise = 0.0;
    end

    always @(negedge we_n) begin
        wa = addr;
        if (ce_n || !oe_n || !vpp) viol++;
    end

    // commands are ignored without the program supply, as the real part does
    always @(posedge we_n) begin
        if (!ce_n && vpp) begin
            t_wrise = $realtime;
            if (mode == M_PROGGING) begin
                pulses++;
                if ($realtime - t_pulse < 10000.0) viol++;
                else if (pulses > skip_until) mem[pa] = mem[pa] & pd;
            end
            if (mode == M_ERASING) begin
                erases++;
                if ($realtime - t_pulse < ERASE_NS) viol++;
                else for (int a = 0; a < 131072; a++) mem[a] = 8'hff;
            end
            if (mode == M_PROG1) begin
                pa = wa;
                pd = bus;
                mode = M_PROGGING;
                t_pulse = $realtime;
            end else if (bus == 8'hff && prev == 8'hff) mode = M_READ;
            else case (bus)
                8'h00: mode = M_READ;
                8'h90: mode = M_SIG;
                8'h20: begin
                    mode = (mode == M_ERASE1) ? M_ERASING : M_ERASE1;
                    t_pulse = $realtime;
                end
                8'ha0: begin
                    mode = M_EVER;
                    va = wa;
                end
                8'h40: mode = M_PROG1;
                8'hc0: mode = M_PVER;
                default: mode = M_READ;
            endcase
            prev = bus;
        end
    end

    always @(negedge oe_n) begin
        if (!ce_n && (mode == M_EVER || mode == M_PVER) && $realtime - t_wrise < 6000.0) viol++;
        if (!ce_n && sig_hv && (addr & 17'h1fffe) != 17'h00000) viol++;
    end

    assign q = (sig_hv || mode == M_SIG) ? (addr[0] ? DEV_CODE : MFG_CODE) :
        mem[(mode == M_EVER) ? va : (mode == M_PVER) ? pa : addr];
    // a released bus shows the inverse so a stale byte can never pass
    assign dev_q = (!ce_n && !oe_n && we_n) ? q : ~q;
endmodule

// ==== tb/flash_host_test.sv ====
// self-checking bench for flash_host against the behavioural flash device
// assumes flash_device_model in tb/ and a shortened erase pulse
`timescale 1ns/100ps
`include "flash_host_regs.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end

module flash_host_test;
    import flash_host_pkg::*;
    localparam logic [7:0] MFG = 8'h5c;
    localparam logic [7:0] DEV = 8'h3a;
    logic ref_clk, rst, cmd_valid, cmd_ready, abort_req, resp_valid, resp_ok, vpp_en, sig_hv_en;
    logic ce_n, oe_n, we_n, data_lines_oe_n;
    op_e cmd_op;
    logic [16:0] cmd_addr, addr_lines, a;
    logic [7:0] cmd_data, resp_data, data_lines_out, dev_q, bus, d;
    logic [15:0] lfsr;
    int fails, samples_checked, skip_until, p0;

    assign bus = data_lines_oe_n ? dev_q : data_lines_out;

    flash_host #(.ERASE_CYC(20)) flash_host_inst (.ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .abort_req(abort_req),
        .resp_valid(resp_valid), .resp_data(resp_data), .resp_ok(resp_ok), .vpp_en(vpp_en), .sig_hv_en(sig_hv_en),
        .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr_lines(addr_lines), .data_lines_out(data_lines_out),
        .data_lines_oe_n(data_lines_oe_n), .data_lines_in(bus));

    flash_device_model #(.MFG_CODE(MFG), .DEV_CODE(DEV), .ERASE_NS(160.0)) flash_device_model_inst (
        .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .vpp(vpp_en), .sig_hv(sig_hv_en), .addr(addr_lines),
        .bus(bus), .skip_until(skip_until), .dev_q(dev_q));

    function automatic logic [7:0] init_byte(input logic [16:0] x);
        return {1'b0, x[6:0] ^ x[13:7]};
    endfunction

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic run(input op_e op, input logic [16:0] x, input logic [7:0] y);
        @(negedge ref_clk);
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_addr = x;
        cmd_data = y;
        @(negedge ref_clk);
        cmd_valid = 1'b0;
        for (int n = 0; n < 60000 && resp_valid !== 1'b1; n++) @(negedge ref_clk);
        if (resp_valid !== 1'b1) begin
            fails++;
            results();
        end
    endtask

    task automatic results();
        $display("checks %0d fails %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // a full failing program run is about 52k cycles; the rest stays well under 20k
    initial begin
        repeat (95000) @(posedge ref_clk);
        fails++;
        results();
    end

    initial begin
        fails = 0;
        samples_checked = 0;
        skip_until = 0;
        lfsr = 16'h005a;
        rst = 1'b1;
        abort_req = 1'b0;
        cmd_valid = 1'b0;
        cmd_op = OP_READ;
        cmd_addr = 17'h00000;
        cmd_data = 8'h00;
        repeat (16) @(negedge ref_clk);
        `CHK("cmd_ready", 1'b1, cmd_ready)
        `CHK("ce_n", 1'b1, ce_n)
        rst = 1'b0;
        for (int i = 0; i < 5; i++) begin
            lfsr = lfsr_next(lfsr);
            a = (i == 4) ? 17'h1ffff : {lfsr[5], lfsr};
            run(OP_READ, a, 8'h00);
            `CHK("read data", init_byte(a), resp_data)
        end
        $display("read test done");
        for (int i = 0; i < 2; i++) begin
            run(OP_SIG_HV, 17'(i), 8'h00);
            `CHK("hv signature", i ? DEV : MFG, resp_data)
            run(OP_SIG_CMD, 17'(i), 8'h00);
            `CHK("cmd signature", i ? DEV : MFG, resp_data)
        end
        run(OP_READ, 17'h00001, 8'h00);
        `CHK("read after signature", init_byte(17'h00001), resp_data)
        $display("signature test done");
        lfsr = lfsr_next(lfsr);
        a = {1'b1, lfsr};
        d = init_byte(a) & lfsr[15:8];
        p0 = flash_device_model_inst.pulses;
        skip_until = p0 + 2;
        run(OP_PROGRAM, a, d);
        `CHK("program ok", 1'b1, resp_ok)
        `CHK("program pulses", p0 + 3, flash_device_model_inst.pulses)
        run(OP_READ, a, 8'h00);
        `CHK("programmed byte", d, resp_data)
        $display("program test done");
        a = 17'h00003;
        p0 = flash_device_model_inst.pulses;
        run(OP_PROGRAM, a, ~init_byte(a));
        `CHK("stuck program ok", 1'b0, resp_ok)
        `CHK("stuck program pulses", p0 + 25, flash_device_model_inst.pulses)
        $display("program limit test done");
        run(OP_ABORT, 17'h00000, 8'h00);
        `CHK("abort ok", 1'b1, resp_ok)
        fork
            begin
                repeat (300) @(negedge ref_clk);
                abort_req = 1'b1;
            end
        join_none
        run(OP_ERASE, 17'h00000, 8'h00);
        abort_req = 1'b0;
        `CHK("aborted erase ok", 1'b0, resp_ok)
        `CHK("erase pulses", 1, flash_device_model_inst.erases)
        run(OP_READ, 17'h00005, 8'h00);
        `CHK("erased byte", 8'hff, resp_data)
        `CHK("pin violations", 0, flash_device_model_inst.viol)
        $display("erase abort test done");
        results();
    end
endmodule
